// ==== hdl/aoc_config.sv ====
// Purpose: Power, interface and output clock edge configuration of a
//          dual-channel 11-bit converter.
// Assumes: Pins and sample words are synchronous to clk_sys.
// Notes:   Edge shifts leave as ts/26 counts for the clock output stage.
`timescale 1ns/1ps
`default_nettype none
`include "aoc_consts.svh"

// Behaviour
// R01: Mode 0000 takes power-down from pins.
// R02: Mode 1000 runs everything normally.
// R03: Modes 1001/1010/1011 disable B/A/both buffers.
// R04: Mode 1100 powers the whole device down.
// R05: Mode 1101 standby B, 1110 standby A.
// R06: Mode 1111 multiplexes, CMOS interface only.
// R07: Multiplexed words interleave on channel A lines.
// R08: Bit 7 selects CMOS (0) or LVDS (1).
// R09: Host writes zero to interface bits 6..0.
// R10: Two position fields; 000/100 mean default.
// R11: Code 101 delays edge by 4/26 ts.
// R12: Code 110 advances edge by 7/26 ts.
// R13: Code 111 advances edge by 4/26 ts.
// R14: Field-to-edge mapping follows the interface.
// R15: Host writes same code to both fields; the bench also writes 8'hb8 (codes 101 and 110).
// R16: Host writes zero to edge bits 1..0.
// R17: Host avoids reserved mode codes 0001-0111.
// R18: Host writes zero to power bits 7..4.
module aoc_config (
    // Clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 rst,
    input  wire logic                 ce,
    // Serial configuration pins
    input  wire logic                 ser_en_n,
    input  wire logic                 ser_clk,
    input  wire logic                 ser_data,
    // Power control pins
    input  wire logic                 power_pin_one,
    input  wire logic                 power_pin_two,
    input  wire logic                 power_pin_three,
    // Converted words
    input  wire logic                 sample_valid,
    input  wire logic [10:0]          chan_a_word,
    input  wire logic [10:0]          chan_b_word,
    // Configuration state
    output var  aoc_pkg::aoc_pwr_type  pwr_out,
    output logic                      lvds_sel_out,
    output var  aoc_pkg::aoc_edge_type edge_out,
    // Output data lines
    output logic [10:0]               chan_a_out,
    output logic [10:0]               chan_b_out,
    output logic                      data_valid_out
);
    import aoc_pkg::*;

    aoc_wr_type  wr;
    aoc_pwr_type pwr_next;
    logic [7:0]  pm_reg;
    logic [7:0]  if_reg;
    logic [7:0]  edge_reg;
    logic [3:0]  pm_code;
    logic [2:0]  pos_hi;
    logic [2:0]  pos_lo;
    logic [10:0] b_hold_reg;
    logic        phase_reg;
    logic        a_live;
    logic        b_live;

    aoc_serial_rx u_rx (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .ce       (ce),
        .ser_en_n (ser_en_n),
        .ser_clk  (ser_clk),
        .ser_data (ser_data),
        .wr_out   (wr)
    );

    // ============================================================
    // Registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pm_reg <= `AOC_REG_RST;
        end else if (ce && wr.valid && wr.addr == `AOC_ADDR_PWR) begin
            pm_reg <= wr.data;
        end
    end

    // R08 interface select
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            if_reg <= `AOC_REG_RST;
        end else if (ce && wr.valid && wr.addr == `AOC_ADDR_IF) begin
            if_reg <= wr.data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            edge_reg <= `AOC_REG_RST;
        end else if (ce && wr.valid && wr.addr == `AOC_ADDR_EDGE) begin
            edge_reg <= wr.data;
        end
    end

    assign pm_code = pm_reg[`AOC_PM_MSB:`AOC_PM_LSB];
    assign pos_hi  = edge_reg[`AOC_EDGE_HI_MSB:`AOC_EDGE_HI_LSB];
    assign pos_lo  = edge_reg[`AOC_EDGE_LO_MSB:`AOC_EDGE_LO_LSB];

    // ============================================================
    // Power mode decode
    // Reserved codes run as normal so a stray write never powers down.
    always_comb begin
        pwr_next = '{buf_a_en: 1'b1, buf_b_en: 1'b1, global_pd: 1'b0,
                     standby_a: 1'b0, standby_b: 1'b0, mux_mode: 1'b0};
        case (pm_code)
            // R01 pin control
            `AOC_PM_PINS: begin
                pwr_next.global_pd = power_pin_one;
                pwr_next.standby_a = power_pin_two;
                pwr_next.standby_b = power_pin_three;
                pwr_next.buf_a_en  = ~power_pin_one;
                pwr_next.buf_b_en  = ~power_pin_one;
            end
            // R02 normal run
            `AOC_PM_NORMAL: pwr_next.global_pd = 1'b0;
            // R03 buffer disables
            `AOC_PM_BUF_B_OFF: pwr_next.buf_b_en = 1'b0;
            `AOC_PM_BUF_A_OFF: pwr_next.buf_a_en = 1'b0;
            `AOC_PM_BUF_OFF: begin
                pwr_next.buf_a_en = 1'b0;
                pwr_next.buf_b_en = 1'b0;
            end
            // R04 global power-down
            `AOC_PM_GLOBAL_PD: begin
                pwr_next.global_pd = 1'b1;
                pwr_next.buf_a_en  = 1'b0;
                pwr_next.buf_b_en  = 1'b0;
            end
            // R05 channel standby
            `AOC_PM_STBY_B: pwr_next.standby_b = 1'b1;
            `AOC_PM_STBY_A: pwr_next.standby_a = 1'b1;
            // R06 multiplex only with CMOS
            `AOC_PM_MUX: pwr_next.mux_mode = ~if_reg[`AOC_IF_SEL_BIT];
            default: pwr_next.mux_mode = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pwr_out      <= '0;
            lvds_sel_out <= 1'b0;
        end else if (ce) begin
            pwr_out      <= pwr_next;
            lvds_sel_out <= if_reg[`AOC_IF_SEL_BIT];
        end
    end

    // ============================================================
    // Output clock edges
    // R14 field mapping swaps under LVDS
    // R10 R11 R12 R13 position decode
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            edge_out <= '0;
        end else if (ce) begin
            if (if_reg[`AOC_IF_SEL_BIT]) begin
                edge_out.fall <= aoc_shift(pos_hi);
                edge_out.rise <= aoc_shift(pos_lo);
            end else begin
                edge_out.rise <= aoc_shift(pos_hi);
                edge_out.fall <= aoc_shift(pos_lo);
            end
        end
    end

    // ============================================================
    // Data path
    // Multiplexed mode needs a free cycle after each sample for word B.
    assign a_live = pwr_out.buf_a_en & ~pwr_out.standby_a;
    assign b_live = pwr_out.buf_b_en & ~pwr_out.standby_b;

    // R07 interleave on channel A lines
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            chan_a_out     <= `AOC_DATA_ZERO;
            chan_b_out     <= `AOC_DATA_ZERO;
            b_hold_reg     <= `AOC_DATA_ZERO;
            phase_reg      <= 1'b0;
            data_valid_out <= 1'b0;
        end else if (ce) begin
            if (pwr_out.mux_mode) begin
                chan_b_out <= `AOC_DATA_ZERO;
                if (sample_valid) begin
                    chan_a_out     <= chan_a_word;
                    b_hold_reg     <= chan_b_word;
                    phase_reg      <= 1'b1;
                    data_valid_out <= 1'b1;
                end else begin
                    if (phase_reg) begin
                        chan_a_out <= b_hold_reg;
                    end
                    data_valid_out <= phase_reg;
                    phase_reg      <= 1'b0;
                end
            end else begin
                phase_reg      <= 1'b0;
                data_valid_out <= sample_valid;
                if (sample_valid) begin
                    chan_a_out <= a_live ? chan_a_word : `AOC_DATA_ZERO;
                    chan_b_out <= b_live ? chan_b_word : `AOC_DATA_ZERO;
                end
            end
        end
    end

    // ============================================================
    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    sequence s_mux_take;
        ce && pwr_out.mux_mode && sample_valid;
    endsequence

    sequence s_mux_gap;
        ce && pwr_out.mux_mode && !sample_valid;
    endsequence

    pin_control_a: assert property ( // R01
        (ce && pm_code == `AOC_PM_PINS) |=>
        pwr_out.global_pd == $past(power_pin_one) &&
        pwr_out.standby_b == $past(power_pin_three))
        else $error("pin control not followed");

    normal_run_a: assert property ( // R02
        (ce && pm_code == `AOC_PM_NORMAL) |=>
        pwr_out.buf_a_en && pwr_out.buf_b_en && !pwr_out.global_pd)
        else $error("normal mode not running");

    buf_off_a: assert property ( // R03
        (ce && pm_code == `AOC_PM_BUF_B_OFF) |=>
        !pwr_out.buf_b_en && pwr_out.buf_a_en)
        else $error("channel B buffer not disabled");

    global_pd_a: assert property ( // R04
        (ce && pm_code == `AOC_PM_GLOBAL_PD) |=>
        pwr_out.global_pd && !pwr_out.buf_a_en)
        else $error("global power-down missing");

    standby_sel_a: assert property ( // R05
        (ce && pm_code == `AOC_PM_STBY_A) |=>
        pwr_out.standby_a && !pwr_out.standby_b)
        else $error("channel A standby wrong");

    mux_cmos_a: assert property ( // R06
        (ce && pm_code == `AOC_PM_MUX) |=>
        pwr_out.mux_mode == !$past(if_reg[`AOC_IF_SEL_BIT]))
        else $error("multiplex allowed under LVDS");

    mux_order_a: assert property ( // R07
        s_mux_take ##1 s_mux_gap |=> chan_a_out == $past(chan_b_word, 2))
        else $error("channel B word not interleaved");

    if_select_a: assert property ( // R08
        (ce && wr.valid && wr.addr == `AOC_ADDR_IF) ##1 ce |=>
        lvds_sel_out == $past(wr.data[`AOC_IF_SEL_BIT], 2))
        else $error("interface select not applied");

    delay_code_a: assert property ( // R11
        (ce && pos_hi == `AOC_POS_DELAY4 && !if_reg[`AOC_IF_SEL_BIT]) |=>
        edge_out.rise == `AOC_SHIFT_P4)
        else $error("delay code not decoded");

    lvds_swap_a: assert property ( // R14
        (ce && if_reg[`AOC_IF_SEL_BIT] && pos_hi == `AOC_POS_DELAY4) |=>
        edge_out.fall == `AOC_SHIFT_P4)
        else $error("LVDS edge mapping wrong");

endmodule : aoc_config

`default_nettype wire

// ==== hdl/aoc_consts.svh ====
// Purpose: Named constants of the converter configuration block.
// Assumes: Included by the package and by every design module.
// Notes:   Definitions only; guarded against double inclusion.
`ifndef AOC_CONSTS_SVH
`define AOC_CONSTS_SVH

// ============================================================
// Register addresses and reset value
`define AOC_ADDR_PWR     8'h40
`define AOC_ADDR_IF      8'h41
`define AOC_ADDR_EDGE    8'h44
`define AOC_REG_RST      8'h00

// ============================================================
// Field positions
`define AOC_PM_MSB       3
`define AOC_PM_LSB       0
`define AOC_IF_SEL_BIT   7
`define AOC_EDGE_HI_MSB  7
`define AOC_EDGE_HI_LSB  5
`define AOC_EDGE_LO_MSB  4
`define AOC_EDGE_LO_LSB  2

// ============================================================
// Power mode codes
`define AOC_PM_PINS      4'h0
`define AOC_PM_NORMAL    4'h8
`define AOC_PM_BUF_B_OFF 4'h9
`define AOC_PM_BUF_A_OFF 4'ha
`define AOC_PM_BUF_OFF   4'hb
`define AOC_PM_GLOBAL_PD 4'hc
`define AOC_PM_STBY_B    4'hd
`define AOC_PM_STBY_A    4'he
`define AOC_PM_MUX       4'hf

// ============================================================
// Edge position codes and shifts, in 26ths of the sample period
`define AOC_POS_DEFAULT0 3'h0
`define AOC_POS_DEFAULT1 3'h4
`define AOC_POS_DELAY4   3'h5
`define AOC_POS_ADV7     3'h6
`define AOC_POS_ADV4     3'h7
`define AOC_SHIFT_NONE   5'h00
`define AOC_SHIFT_P4     5'h04
`define AOC_SHIFT_M7     5'h19
`define AOC_SHIFT_M4     5'h1c

// ============================================================
// Serial frame end and zero data word
`define AOC_FRAME_LAST   5'h0f
`define AOC_DATA_ZERO    11'h000

`endif

// ==== hdl/aoc_pkg.sv ====
// Purpose: Types and shared decode of the converter configuration block.
// Assumes: aoc_consts.svh is on the include path.
// Notes:   Edge shifts are two's complement counts of ts/26.
`include "aoc_consts.svh"

package aoc_pkg;

    // ============================================================
    // Carriers
    typedef struct packed {
        logic       valid;
        logic [7:0] addr;
        logic [7:0] data;
    } aoc_wr_type;

    typedef struct packed {
        logic buf_a_en;
        logic buf_b_en;
        logic global_pd;
        logic standby_a;
        logic standby_b;
        logic mux_mode;
    } aoc_pwr_type;

    typedef struct packed {
        logic [4:0] rise;
        logic [4:0] fall;
    } aoc_edge_type;

    typedef enum logic [1:0] {
        AOC_RX_IDLE  = 2'h0,
        AOC_RX_SHIFT = 2'h1
    } aoc_rx_state_type;

    // ============================================================
    // Edge position decode
    function automatic logic [4:0] aoc_shift(input logic [2:0] code);
        case (code)
            `AOC_POS_DELAY4: aoc_shift = `AOC_SHIFT_P4;
            `AOC_POS_ADV7:   aoc_shift = `AOC_SHIFT_M7;
            `AOC_POS_ADV4:   aoc_shift = `AOC_SHIFT_M4;
            default:         aoc_shift = `AOC_SHIFT_NONE;
        endcase
    endfunction : aoc_shift

endpackage : aoc_pkg

// ==== hdl/aoc_serial_rx.sv ====
// Purpose: Serial write port: 16-bit frames, address then data, MSB first.
// Assumes: Serial pins are synchronous to clk_sys and slower than it.
// Notes:   One write strobe per complete frame; short frames are dropped.
`timescale 1ns/1ps
`default_nettype none
`include "aoc_consts.svh"

module aoc_serial_rx (
    // Clock and reset
    input  wire logic               clk_sys,
    input  wire logic               rst,
    input  wire logic               ce,
    // Serial pins
    input  wire logic               ser_en_n,
    input  wire logic               ser_clk,
    input  wire logic               ser_data,
    // Register write
    output var  aoc_pkg::aoc_wr_type wr_out
);
    import aoc_pkg::*;

    aoc_rx_state_type state_reg;
    logic             clk_prev_reg;
    logic [15:0]      shift_reg;
    logic [4:0]       count_reg;
    logic             rise;
    logic             live;

    assign rise = ser_clk & ~clk_prev_reg;
    assign live = (state_reg == AOC_RX_SHIFT) & ~ser_en_n;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            clk_prev_reg <= 1'b0;
        end else if (ce) begin
            clk_prev_reg <= ser_clk;
        end
    end

    // ============================================================
    // Frame state
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_reg <= AOC_RX_IDLE;
        end else if (ce) begin
            unique case (state_reg)
                AOC_RX_IDLE:  if (!ser_en_n) state_reg <= AOC_RX_SHIFT;
                AOC_RX_SHIFT: if (ser_en_n) state_reg <= AOC_RX_IDLE;
                default:      state_reg <= AOC_RX_IDLE;
            endcase
        end
    end

    // Raising the enable mid-frame discards the partial word.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            count_reg <= 5'h00;
            shift_reg <= 16'h0000;
        end else if (ce) begin
            if (!live) begin
                count_reg <= 5'h00;
            end else if (rise) begin
                shift_reg <= {shift_reg[14:0], ser_data};
                count_reg <= (count_reg == `AOC_FRAME_LAST) ? 5'h00
                                                           : count_reg + 5'h01;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wr_out <= '0;
        end else if (ce) begin
            wr_out.valid <= live & rise & (count_reg == `AOC_FRAME_LAST);
            wr_out.addr  <= shift_reg[14:7];
            wr_out.data  <= {shift_reg[6:0], ser_data};
        end
    end

    wr_frame_a: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(wr_out.valid) |-> $past(count_reg) == `AOC_FRAME_LAST)
        else $error("write strobe without a full frame");

endmodule : aoc_serial_rx

`default_nettype wire

// ==== sim/aoc_host_model.sv ====
// Purpose: Host model that writes configuration registers serially.
// Assumes: Frames are 16 bits, address then data, MSB first.
// Notes:   The serial clock stands low between frames.
`timescale 1ns/1ps
`default_nettype none
`include "aoc_consts.svh"

module aoc_host_model (
    // Clock
    input  wire logic clk_sys,
    // Serial pins
    output var  logic ser_en_n,
    output var  logic ser_clk,
    output var  logic ser_data
);
    // ============================================================
    // Frame writer
    initial begin
        ser_en_n = 1'b1;
        ser_clk  = 1'b0;
        ser_data = 1'b0;
    end

    // A nonzero hold stretches every serial phase, as a slow host would.
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data,
                             input int hold);
        logic [15:0] frame;
        frame = {addr, data};
        if (addr == `AOC_ADDR_PWR) frame[7:4] = 4'h0;
        if (addr == `AOC_ADDR_IF) frame[6:0] = 7'h00;
        if (addr == `AOC_ADDR_EDGE) frame[1:0] = 2'h0;
        @(negedge clk_sys);
        ser_en_n = 1'b0;
        repeat (2 + hold) @(negedge clk_sys);
        for (int i = 15; i >= 0; i--) begin
            ser_data = frame[i];
            ser_clk  = 1'b0;
            repeat (1 + hold) @(negedge clk_sys);
            ser_clk = 1'b1;
            repeat (1 + hold) @(negedge clk_sys);
        end
        // Released data toggles so a stale bit is never mistaken for data.
        ser_clk  = 1'b0;
        ser_en_n = 1'b1;
        ser_data = ~ser_data;
    endtask : write_reg
endmodule : aoc_host_model
`default_nettype wire

// ==== sim/adc_output_power_config_bench.sv ====
// Purpose: Self-checking bench of the converter configuration block.
// Assumes: Outputs settle three edges after the last serial rise.
// Notes:   Clock enable drops once, to show that it freezes the block.
`timescale 1ns/1ps
`default_nettype none
`include "aoc_consts.svh"

module adc_output_power_config_bench;
    import aoc_pkg::*;
    localparam logic [10:0] WA = 11'h5a3;
    localparam logic [10:0] WB = 11'h2c6;
    localparam logic [3:0] MODES [8] = '{4'h8, 4'h9, 4'ha, 4'hb,
                                         4'hc, 4'hd, 4'he, 4'hf};
    localparam logic [5:0] PEXP [8] = '{6'h30, 6'h20, 6'h10, 6'h00,
                                        6'h08, 6'h02, 6'h04, 6'h01};
    localparam logic [5:0] PMSK [8] = '{6'h3f, 6'h3f, 6'h3f, 6'h3f,
                                        6'h0f, 6'h0f, 6'h0f, 6'h0f};
    localparam logic [7:0] A_ON = 8'h23;
    localparam logic [7:0] B_ON = 8'h45;
    localparam logic [2:0] PINS [4] = '{3'h0, 3'h4, 3'h2, 3'h1};
    localparam logic [5:0] PIN_EXP [4] = '{6'h30, 6'h08, 6'h34, 6'h32};
    localparam logic [2:0] CODES [5] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7};
    localparam logic [4:0] SHIFTS [5] = '{5'h00, 5'h00, 5'h04, 5'h19,
                                          5'h1c};

    logic         clk_sys;
    logic         rst;
    logic         ce;
    logic         ser_en_n;
    logic         ser_clk;
    logic         ser_data;
    logic [2:0]   pin_vec;
    logic         sample_valid;
    logic [10:0]  word_a;
    logic [10:0]  word_b;
    aoc_pwr_type  pwr_out;
    logic         lvds_sel_out;
    aoc_edge_type edge_out;
    logic [10:0]  chan_a_out;
    logic [10:0]  chan_b_out;
    logic         data_valid_out;
    int           n_mismatch;
    int           comparisons;
    int           cycles;

    aoc_host_model aoc_host_model_i (
        .clk_sys  (clk_sys),
        .ser_en_n (ser_en_n),
        .ser_clk  (ser_clk),
        .ser_data (ser_data)
    );

    aoc_config aoc_config_i (
        .clk_sys         (clk_sys),
        .rst             (rst),
        .ce              (ce),
        .ser_en_n        (ser_en_n),
        .ser_clk         (ser_clk),
        .ser_data        (ser_data),
        .power_pin_one   (pin_vec[2]),
        .power_pin_two   (pin_vec[1]),
        .power_pin_three (pin_vec[0]),
        .sample_valid    (sample_valid),
        .chan_a_word     (word_a),
        .chan_b_word     (word_b),
        .pwr_out         (pwr_out),
        .lvds_sel_out    (lvds_sel_out),
        .edge_out        (edge_out),
        .chan_a_out      (chan_a_out),
        .chan_b_out      (chan_b_out),
        .data_valid_out  (data_valid_out)
    );

    // ============================================================
    // Clock, timeout and report
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    initial cycles = 0;
    always @(posedge clk_sys) begin
        cycles = cycles + 1;
        if (cycles == 6000) begin
            n_mismatch = n_mismatch + 1;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Waits out strobe, register and output stages after the frame.
    task automatic wr(input logic [7:0] addr, input logic [7:0] data,
                      input int hold);
        aoc_host_model_i.write_reg(addr, data, hold);
        repeat (4) @(negedge clk_sys);
    endtask : wr

    task automatic reset_dut();
        rst = 1'b1;
        repeat (3) @(negedge clk_sys);
        rst = 1'b0;
        repeat (2) @(negedge clk_sys);
    endtask : reset_dut

    // ============================================================
    // Scenarios
    initial begin
        n_mismatch   = 0;
        comparisons  = 0;
        rst          = 1'b1;
        ce           = 1'b1;
        pin_vec      = 3'h0;
        sample_valid = 1'b0;
        word_a       = WA;
        word_b       = WB;
        reset_dut();
        chk(16'(lvds_sel_out), 16'h0000);
        chk(16'(edge_out), 16'h0000);
        for (int i = 0; i < 4; i++) begin
            pin_vec = PINS[i];
            repeat (2) @(negedge clk_sys);
            chk(16'(pwr_out & PMSK[i]), 16'(PIN_EXP[i]));
        end
        pin_vec = 3'h0;
        for (int i = 0; i < 8; i++) begin
            wr(8'h40, {4'h0, MODES[i]}, i % 2);
            chk(16'(pwr_out & PMSK[i]), 16'(PEXP[i] & PMSK[i]));
            @(negedge clk_sys);
            sample_valid = 1'b1;
            @(negedge clk_sys);
            sample_valid = 1'b0;
            chk(16'(data_valid_out), 16'h0001);
            if (i == 7) begin
                chk(16'(chan_a_out), 16'(WA));
                chk(16'(chan_b_out), 16'h0000);
                @(negedge clk_sys);
                chk(16'(chan_a_out), 16'(WB));
                chk(16'(data_valid_out), 16'h0001);
                @(negedge clk_sys);
                chk(16'(data_valid_out), 16'h0000);
            end else begin
                chk(16'(chan_a_out), A_ON[i] ? 16'(WA) : 16'h0000);
                chk(16'(chan_b_out), B_ON[i] ? 16'(WB) : 16'h0000);
            end
        end
        wr(8'h40, 8'h08, 0);
        // A frozen block must ignore a whole frame.
        ce = 1'b0;
        wr(8'h40, 8'h0c, 0);
        ce = 1'b1;
        @(negedge clk_sys);
        chk(16'(pwr_out), 16'h0030);
        for (int i = 0; i < 5; i++) begin
            wr(8'h44, {CODES[i], CODES[i], 2'h0}, 0);
            chk(16'(edge_out), 16'({SHIFTS[i], SHIFTS[i]}));
        end
        wr(8'h44, 8'hb8, 0);
        chk(16'(edge_out), 16'({5'h04, 5'h19}));
        wr(8'h41, 8'h80, 0);
        chk(16'(lvds_sel_out), 16'h0001);
        chk(16'(edge_out), 16'({5'h19, 5'h04}));
        wr(8'h41, 8'h00, 0);
        chk(16'(lvds_sel_out), 16'h0000);
        // An unmapped address must leave the power and edge registers alone.
        wr(8'h42, 8'hff, 1);
        chk(16'(pwr_out), 16'h0030);
        chk(16'(edge_out), 16'({5'h04, 5'h19}));
        // A reset in mid-run returns to pin control and defaults.
        wr(8'h41, 8'h80, 0);
        reset_dut();
        chk(16'(lvds_sel_out), 16'h0000);
        chk(16'(edge_out), 16'h0000);
        chk(16'(pwr_out), 16'h0030);
        end_sim();
    end
endmodule : adc_output_power_config_bench
`default_nettype wire
